//--- pkg/sbcp_pkg.sv
/*
  Shared constants for the serial register port: frame layout, register
  map, reset values, mode codes and frame phases.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sbcp_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int NREG = 19;
  localparam int IDX_W = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = IDX_W + 4;

  // frame field positions
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 10;
  localparam int RW_MSB = 9;
  localparam int RW_LSB = 8;
  localparam int PAR_MSB = 7;
  localparam int PAR_LSB = 4;
  localparam int DATA_MSB = 3;
  localparam int DATA_LSB = 0;

  localparam logic [4:0] HDR_LEN = 5'h08;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] OVERRUN_LEN = 5'h11;

  localparam logic [1:0] RW_WRITE = 2'h3;
  localparam logic [1:0] RW_READ = 2'h0;

  localparam logic [2:0] MODE_NREQ = 3'h0;
  localparam logic [2:0] MODE_NORMAL = 3'h1;
  localparam logic [2:0] MODE_STBY = 3'h2;
  localparam logic [2:0] MODE_SLEEP = 3'h4;
  localparam logic [2:0] MODE_EMERG = 3'h7;

  // index 0 mode_control, 1 mode_control_confirm, 2 switched_supply_control,
  // 3 cyclic_timing_control, 4 watchdog_control, 5 ground_shift_level,
  // 6 wake_input_control, 7 wake_input_status, 8 wake_input_live_level,
  // 9 overtemp_status, 10 bus_high_line_error_status,
  // 11 bus_low_line_error_status, 12 reset_cause, 13 supply_status,
  // 14 irq_mask_a, 15 irq_mask_b, 16 irq_source_a, 17 irq_source_b,
  // 18 transceiver_control
  localparam logic [5:0] REG_ADDR [NREG] = '{
    6'h00, 6'h03, 6'h05, 6'h06, 6'h09, 6'h0a, 6'h0c, 6'h0f, 6'h11, 6'h12,
    6'h14, 6'h17, 6'h18, 6'h1b, 6'h1d, 6'h1e, 6'h21, 6'h22, 6'h24};
  localparam logic [NREG-1:0] REG_WRITABLE = 19'h4c07f;
  localparam logic [3:0] REG_RESET [NREG] = '{
    4'h0, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
    4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  localparam logic [IDX_W-1:0] IDX_MODE_CONTROL = 5'h00;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HEADER,
    PH_PAYLOAD,
    PH_OVERRUN
  } sbcp_phase_e;

endpackage

//--- logic/sbcp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides, width and depth set by
  parameters. Assumes one clock and an already synchronised reset.
*/
`timescale 1ns/1ps
module sbcp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk, // clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // word to store
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

//--- logic/sbcp_port.sv
/*
  Serial slave register port of the system base device: pin sampling,
  16-bit frame shift, readback, frame check, write commit through a FIFO
  into the control register file.
  Assumes the pins arrive asynchronously to clk and that mode_state and
  status_regs come from logic on clk.
*/
// Summary of operation
// RULE_01: transfers accepted only while select is low
// RULE_02: data-out driven only while selected
// RULE_03: commit write on select release if valid
// RULE_04: host keeps clock low at select edges
// RULE_05: host should idle clock low when deselected
// RULE_06: deselected clock and data changes ignored
// RULE_07: sample data-in on serial clock fall
// RULE_08: update data-out on serial clock rise
// RULE_09: frame is exactly sixteen bits
// RULE_10: most significant bit first both ways
// RULE_11: bits 15-10 address, 9-8 flags
// RULE_12: bits 7-4 check, 3-0 payload
// RULE_13: port active only in powered modes
// RULE_14: sleep mode: select activity requests wake-up
// RULE_15: return addressed register within same frame
// RULE_16: nineteen fixed addresses, others invalid
// RULE_17: check bits computed from payload nibble
// RULE_18: write flags both one, read both zero
// RULE_19: read returns old header, then new data
// RULE_20: bad address or check: discard, flag, interrupt
// RULE_21: short frame commits nothing
`timescale 1ns/1ps
module sbcp_port
  import sbcp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic cs_n, // chip select pin, active low
  input wire logic sclk, // serial clock pin
  input wire logic mosi, // serial data in pin
  output logic miso, // serial data out
  output logic miso_oe, // data out driver enable
  input wire logic [2:0] mode_state, // current device mode
  input wire logic [NREG-1:0][3:0] status_regs, // live status nibbles
  input wire logic cfg_ready, // register file may take a write
  input wire logic err_clr, // clears spi_err
  output logic [NREG-1:0][3:0] ctrl_regs, // control register contents
  output logic spi_err, // sticky frame error flag
  output logic err_irq, // one-cycle error interrupt
  output logic wake_req // one-cycle wake-up request
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] check_bits(input logic [3:0] d);
    check_bits = {d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0]}; // RULE_17
  endfunction

  // returns {valid, index}
  function automatic logic [IDX_W:0] decode_addr(input logic [5:0] a);
    decode_addr = '0;
    for (int i = 0; i < NREG; i++) begin
      if (REG_ADDR[i] == a) begin
        decode_addr = {1'b1, IDX_W'(i)}; // RULE_16
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rst_meta_q, rst_sync_q, rsn;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rsn = rst_sync_q;

  logic cs_meta_q, cs_s_q, cs_d_q;
  logic sclk_meta_q, sclk_s_q, sclk_d_q;
  logic mosi_meta_q, mosi_s_q;

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      cs_meta_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      sclk_meta_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_d_q <= 1'b0;
      mosi_meta_q <= 1'b0;
      mosi_s_q <= 1'b0;
    end else begin
      cs_meta_q <= cs_n;
      cs_s_q <= cs_meta_q;
      cs_d_q <= cs_s_q;
      sclk_meta_q <= sclk;
      sclk_s_q <= sclk_meta_q;
      sclk_d_q <= sclk_s_q;
      mosi_meta_q <= mosi;
      mosi_s_q <= mosi_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame control

  logic mode_ok, frame_open_q, sel, end_ev;
  logic sck_fall, sck_rise, cs_fall, cs_rise;

  assign mode_ok = (mode_state == MODE_NREQ) || (mode_state == MODE_NORMAL) ||
                   (mode_state == MODE_STBY); // RULE_13
  assign sck_fall = sclk_d_q && !sclk_s_q;
  assign sck_rise = !sclk_d_q && sclk_s_q;
  assign cs_fall = cs_d_q && !cs_s_q;
  assign cs_rise = !cs_d_q && cs_s_q;
  // edges near select transitions are not filtered; host keeps clock low there
  assign sel = frame_open_q && !cs_s_q && mode_ok; // RULE_01 RULE_06 RULE_04 RULE_05
  assign end_ev = frame_open_q && cs_rise && mode_ok;

  // leaving the powered modes mid-frame abandons the frame
  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      frame_open_q <= 1'b0;
    end else if (!mode_ok || cs_rise) begin
      frame_open_q <= 1'b0;
    end else if (cs_fall) begin
      frame_open_q <= 1'b1;
    end
  end

  sbcp_phase_e phase_q;
  logic [4:0] cnt_q;
  logic [15:0] rx_q, tx_q, last_frame_q;
  logic miso_q, oe_q;
  logic [7:0] hdr;
  logic [IDX_W:0] hdr_dec, f_dec;
  logic [3:0] hdr_rdata;

  // header as it stands after the eighth falling edge
  assign hdr = {rx_q[6:0], mosi_s_q};
  assign hdr_dec = decode_addr(hdr[7:2]);
  assign hdr_rdata = (hdr_dec[IDX_W-1:0] == IDX_MODE_CONTROL) ? {1'b0, mode_state} :
                     REG_WRITABLE[hdr_dec[IDX_W-1:0]] ? ctrl_regs[hdr_dec[IDX_W-1:0]] :
                     status_regs[hdr_dec[IDX_W-1:0]];

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      cnt_q <= '0;
      phase_q <= PH_IDLE;
    end else if (cs_fall && mode_ok) begin
      cnt_q <= '0;
      phase_q <= PH_HEADER;
    end else if (sel && sck_fall && cnt_q != OVERRUN_LEN) begin
      cnt_q <= cnt_q + 5'h01; // RULE_09
      case (phase_q)
        PH_HEADER: begin
          if (cnt_q + 5'h01 == HDR_LEN) begin
            phase_q <= PH_PAYLOAD;
          end
        end
        PH_PAYLOAD: begin
          if (cnt_q + 5'h01 == OVERRUN_LEN) begin
            phase_q <= PH_OVERRUN;
          end
        end
        default: phase_q <= phase_q;
      endcase
    end else if (end_ev || !mode_ok) begin
      phase_q <= PH_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      rx_q <= '0;
    end else if (sel && sck_fall) begin
      rx_q <= {rx_q[14:0], mosi_s_q}; // RULE_07 RULE_10
    end
  end

  // first byte out is the previous header; the addressed register follows
  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      tx_q <= '0;
    end else if (cs_fall && mode_ok) begin
      tx_q <= last_frame_q; // RULE_19
    end else if (sel && sck_fall && phase_q == PH_HEADER && cnt_q + 5'h01 == HDR_LEN &&
                 hdr_dec[IDX_W]) begin
      tx_q[15:8] <= {check_bits(hdr_rdata), hdr_rdata}; // RULE_15 RULE_19 RULE_17
    end else if (sel && sck_rise) begin
      tx_q <= {tx_q[14:0], 1'b0}; // RULE_10
    end
  end

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      miso_q <= 1'b0;
    end else if (sel && sck_rise) begin
      miso_q <= tx_q[15]; // RULE_08
    end
  end

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !cs_s_q && mode_ok; // RULE_02 RULE_13
    end
  end

  assign miso = miso_q;
  assign miso_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // frame check at select release

  logic [5:0] f_addr;
  logic [1:0] f_rw;
  logic [3:0] f_par, f_data;
  logic full_frame, frame_good, want_write, push;
  logic fifo_in_ready, fifo_out_valid, drain;
  logic [FIFO_WIDTH-1:0] fifo_out_data;

  assign f_addr = rx_q[ADDR_MSB:ADDR_LSB]; // RULE_11
  assign f_rw = rx_q[RW_MSB:RW_LSB]; // RULE_11
  assign f_par = rx_q[PAR_MSB:PAR_LSB]; // RULE_12
  assign f_data = rx_q[DATA_MSB:DATA_LSB]; // RULE_12
  assign f_dec = decode_addr(f_addr);
  assign full_frame = (cnt_q == FRAME_LEN); // RULE_21
  assign frame_good = f_dec[IDX_W] && (f_par == check_bits(f_data)); // RULE_20 RULE_17
  // mixed flags neither write nor flag an error; read-only targets ignore writes
  assign want_write = end_ev && full_frame && frame_good && (f_rw == RW_WRITE) &&
                      REG_WRITABLE[f_dec[IDX_W-1:0]]; // RULE_03 RULE_18
  // a full queue refuses the write; the drop is reported as an error
  assign push = want_write && fifo_in_ready;

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      last_frame_q <= '0;
    end else if (end_ev && full_frame) begin
      last_frame_q <= rx_q;
    end
  end

  sbcp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rsn),
    .in_valid(want_write),
    .in_ready(fifo_in_ready),
    .in_data({f_dec[IDX_W-1:0], f_data}),
    .out_valid(fifo_out_valid),
    .out_ready(cfg_ready),
    .out_data(fifo_out_data)
  );

  assign drain = fifo_out_valid && cfg_ready;

  ////////////////////////////////////////////////////////////////////////
  // control register file

  logic [NREG-1:0][3:0] regs_q;

  for (genvar g = 0; g < NREG; g++) begin : g_reg
    if (REG_WRITABLE[g]) begin : g_rw
      always_ff @(posedge clk or negedge rsn) begin
        if (!rsn) begin
          regs_q[g] <= REG_RESET[g];
        end else if (drain && fifo_out_data[FIFO_WIDTH-1:4] == IDX_W'(g)) begin
          regs_q[g] <= fifo_out_data[3:0]; // RULE_03
        end
      end
    end else begin : g_ro
      assign regs_q[g] = 4'h0;
    end
  end

  assign ctrl_regs = regs_q;

  ////////////////////////////////////////////////////////////////////////
  // error flag, interrupt, wake-up

  logic err_q, irq_q, wake_q, bad_ev;

  assign bad_ev = (end_ev && full_frame && !frame_good) || (want_write && !fifo_in_ready);

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      err_q <= 1'b0;
    end else if (bad_ev) begin
      err_q <= 1'b1; // RULE_20
    end else if (err_clr) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= bad_ev; // RULE_20
    end
  end

  always_ff @(posedge clk or negedge rsn) begin
    if (!rsn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= (mode_state == MODE_SLEEP) && cs_fall; // RULE_14
    end
  end

  assign spi_err = err_q;
  assign err_irq = irq_q;
  assign wake_req = wake_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rsn);

  AST_DESEL_HOLDS: assert property (cs_s_q |=> $stable(rx_q) && $stable(cnt_q)) // RULE_06
    else $error("shift state changed while deselected");
  AST_OE_FOLLOWS_SEL: assert property ((!cs_s_q && mode_ok) |=> miso_oe) // RULE_02
    else $error("data out driver not enabled while selected");
  AST_OE_OFF_DESEL: assert property (cs_s_q |=> !miso_oe) // RULE_02
    else $error("data out driven while deselected");
  AST_SAMPLE_FALL: assert property (sel && sck_fall |=> rx_q[0] == $past(mosi_s_q)) // RULE_07
    else $error("data in not sampled on falling edge");
  AST_OUT_ON_RISE: assert property (!(sel && sck_rise) |=> $stable(miso)) // RULE_08
    else $error("data out changed away from a rising edge");
  AST_MSB_OUT: assert property (sel && sck_rise |=> miso == $past(tx_q[15])) // RULE_10
    else $error("data out not msb of shift register");
  AST_COUNT: assert property (sel && sck_fall && cnt_q < FRAME_LEN |=> cnt_q == $past(cnt_q) + 5'h01) // RULE_09
    else $error("bit count did not advance");
  AST_READBACK: assert property (sel && sck_fall && phase_q == PH_HEADER && cnt_q == 5'h07 &&
                                 hdr_dec[IDX_W] |=> tx_q[15:8] == $past({check_bits(hdr_rdata), hdr_rdata})) // RULE_15
    else $error("addressed register not loaded for readback");
  AST_WRITE_VALID: assert property (want_write |-> full_frame && frame_good && f_rw == RW_WRITE) // RULE_03
    else $error("write queued from an invalid frame");
  AST_SHORT_NO_WRITE: assert property (end_ev && !full_frame |-> !want_write) // RULE_21
    else $error("short frame queued a write");
  AST_BAD_FLAGS: assert property (end_ev && full_frame && !frame_good |=> spi_err && err_irq ##1 !err_irq) // RULE_20
    else $error("bad frame did not raise error and one-cycle interrupt");
  AST_INACTIVE: assert property (!mode_ok |=> $stable(rx_q) && !miso_oe) // RULE_13
    else $error("port active outside powered modes");
  AST_WAKE: assert property (mode_state == MODE_SLEEP && cs_fall |=> wake_req) // RULE_14
    else $error("select activity in sleep gave no wake request");

  COV_WRITE: cover property (push);
  COV_READ: cover property (end_ev && full_frame && frame_good && f_rw == RW_READ);
  COV_ERROR: cover property (bad_ev);
  COV_WAKE: cover property (wake_req);

endmodule

//--- verif/sbcp_host.sv
/*
  Host-side serial master model for the register port: frames and idle noise.
  Assumes clk is the device clock; half a serial clock period is 6 clk (48 ns period).
*/
`timescale 1ns/1ps
module sbcp_host (
  input wire logic clk, // bench clock
  output logic cs_n, // select, active low
  output logic sclk, // serial clock
  output logic mosi, // serial data to device
  input wire logic miso // resolved data-out wire
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // nbits of tx go out msb first; what came back lands in rx
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n <= 1'b0;
    wait_clk(6);
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk <= 1'b1;
      mosi <= tx[i];
      wait_clk(6);
      sclk <= 1'b0;
      rx = {rx[14:0], miso};
      wait_clk(6);
    end
    // released line must not keep showing the last bit
    mosi <= ~mosi;
    cs_n <= 1'b1;
    wait_clk(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // toggling while deselected; even n leaves sclk low for the next select
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      sclk <= ~sclk;
      mosi <= ~mosi;
      wait_clk(6);
    end
  endtask
endmodule

//--- verif/tb.sv
/*
  Self-checking bench for the serial register port: writes, readback, bad frames,
  short frames, deselected noise, low-power modes and a stalled write queue.
  Assumes sbcp_host as the far side and the register map of the package.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
  import sbcp_pkg::*;
  logic clk, rst_n, miso, miso_oe, cfg_ready, err_clr, spi_err, err_irq, wake_req;
  logic cs_n, sclk, mosi;
  wire miso_w;
  logic [2:0] mode_state;
  logic [NREG-1:0][3:0] status_regs;
  logic [NREG-1:0][3:0] ctrl_regs;
  logic [3:0] exp_reg [NREG];
  logic [3:0] v;
  logic [15:0] rx, last_tx, prev_tx;
  int errors, total_checks, irq_n, wake_n, cycles, e0;

  assign miso_w = miso_oe ? miso : 1'bz;

  sbcp_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso_w));

  sbcp_port #(.DEPTH(FIFO_DEPTH)) uut (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .mode_state(mode_state), .status_regs(status_regs),
    .cfg_ready(cfg_ready), .err_clr(err_clr), .ctrl_regs(ctrl_regs), .spi_err(spi_err),
    .err_irq(err_irq), .wake_req(wake_req));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // pulse counters and hang guard
  always @(posedge clk) begin
    cycles++;
    if (err_irq === 1'b1) irq_n++;
    if (wake_req === 1'b1) wake_n++;
    if (cycles == 30000) begin
      errors++;
      end_of_test();
    end
  end

  function automatic logic [3:0] chk(input logic [3:0] d);
    return {d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0]};
  endfunction

  function automatic logic [15:0] frm(input logic [5:0] a, input logic [1:0] rw, input logic [3:0] d);
    return {a, rw, chk(d), d};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic go(input logic [15:0] tx, input int n);
    host.xfer(tx, n, rx);
    if (n == 16) begin
      prev_tx = last_tx;
      last_tx = tx;
    end
  endtask

  task automatic check_regs();
    for (int i = 0; i < NREG; i++) begin
      `CHK("ctrl_regs", exp_reg[i], ctrl_regs[i])
    end
  endtask

  // clears the flag, sends one frame, expects err errors and no register change
  task automatic errcase(input logic [15:0] tx, input int n, input logic err);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("spi_err cleared", 1'b0, spi_err)
    e0 = irq_n;
    go(tx, n);
    `CHK("spi_err", err, spi_err)
    `CHK("err_irq count", e0 + int'(err), irq_n)
    check_regs();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    cfg_ready = 1'b1;
    err_clr = 1'b0;
    mode_state = MODE_NORMAL;
    for (int i = 0; i < NREG; i++) begin
      status_regs[i] = 4'(i) ^ 4'ha;
      exp_reg[i] = REG_RESET[i];
    end
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check_regs();
    `CHK("miso_oe idle", 1'b0, miso_oe)
    // read-only targets must be accepted and ignored
    for (int i = 0; i < NREG; i++) begin
      go(frm(REG_ADDR[i], RW_WRITE, 4'(i + 3)), 16);
      if (REG_WRITABLE[i]) exp_reg[i] = 4'(i + 3);
    end
    check_regs();
    `CHK("miso_oe after frame", 1'b0, miso_oe)
    for (int i = 0; i < NREG; i++) begin
      go(frm(REG_ADDR[i], RW_READ, 4'h0), 16);
      v = (i == 0) ? {1'b0, mode_state} : (REG_WRITABLE[i] ? exp_reg[i] : status_regs[i]);
      `CHK("read header", prev_tx[15:8], rx[15:8])
      `CHK("read data", {chk(v), v}, rx[7:0])
    end
    errcase({REG_ADDR[2], RW_WRITE, 4'h0, 4'h5}, 16, 1'b1);
    errcase(frm(6'h01, RW_WRITE, 4'h5), 16, 1'b1);
    errcase(frm(6'h25, RW_WRITE, 4'h5), 16, 1'b1);
    errcase(frm(REG_ADDR[2], 2'h1, 4'h5), 16, 1'b0);
    errcase(frm(REG_ADDR[2], RW_WRITE, 4'h9), 15, 1'b0);
    e0 = irq_n;
    host.noise(8);
    repeat (8) @(posedge clk);
    check_regs();
    `CHK("miso_oe deselected", 1'b0, miso_oe)
    `CHK("noise errors", e0, irq_n)
    // low-power modes: frames ignored, sleep select wakes
    e0 = wake_n;
    mode_state <= MODE_SLEEP;
    go(frm(REG_ADDR[2], RW_WRITE, 4'h6), 16);
    `CHK("wake_req count", e0 + 1, wake_n)
    check_regs();
    mode_state <= MODE_EMERG;
    go(frm(REG_ADDR[2], RW_WRITE, 4'h6), 16);
    `CHK("wake_req emergency", e0 + 1, wake_n)
    check_regs();
    mode_state <= MODE_NORMAL;
    repeat (8) @(posedge clk);
    // stalled register file: eight queue, ninth dropped, drain in order
    cfg_ready <= 1'b0;
    e0 = irq_n;
    for (int k = 1; k <= FIFO_DEPTH + 1; k++) begin
      go(frm(REG_ADDR[2], RW_WRITE, 4'(k)), 16);
    end
    check_regs();
    `CHK("dropped write error", e0 + 1, irq_n)
    cfg_ready <= 1'b1;
    repeat (30) @(posedge clk);
    exp_reg[2] = 4'(FIFO_DEPTH);
    check_regs();
    end_of_test();
  end
endmodule
